/* File: fdl_pkg.sv */
// fdl_pkg: shared constants for the fault diagnosis logic
package fdl_pkg;

  localparam int          NCH           = 2;
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 12;
  localparam int          SETP_W        = 12;

  // register byte addresses
  localparam logic [11:0] ADDR_DIAG     = 12'h000;
  localparam logic [11:0] ADDR_CONFIG   = 12'h004;
  localparam logic [11:0] ADDR_CHAN0    = 12'h008;
  localparam logic [11:0] ADDR_CHAN1    = 12'h00c;
  localparam logic [11:0] ADDR_LIVE     = 12'h010;

  // diagnosis flag positions, per channel c at base + c
  localparam int          DIAG_OVC      = 0;
  localparam int          DIAG_OPENLOAD_BYPASS_FLAG     = 2;
  localparam int          DIAG_OT       = 4;
  localparam int          DIAG_UV       = 6;
  localparam int          DIAG_RE       = 8;
  localparam int          DIAG_PUMP     = 10;
  localparam int          DIAG_BATOV    = 11;
  localparam int          DIAG_CRC      = 12;
  localparam int          DIAG_WDOG     = 13;

  // configuration register fields
  localparam int          CFG_CHMASK    = 0;
  localparam int          CFG_ENMASK    = 2;
  localparam int          CFG_ISEL      = 4;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0007;

  // channel register: enable bit and setpoint
  localparam int          CH_EN         = 16;

  // timing
  localparam int          CLK_MHZ       = 200;
  localparam int          OPENLOAD_BYPASS_FLAG_CYC      = 8192;
  localparam int          OPENLOAD_BYPASS_FLAG_W        = 14;
  localparam int          REG_PWM_LIM   = 8;
  localparam int          READY_NS      = 100;
  localparam int          READY_CYC     = (READY_NS * CLK_MHZ + 999) / 1000;

endpackage : fdl_pkg

/* File: fdl_chan_mon.sv */
// fdl_chan_mon: per-channel on-state open-load timer and regulation-error counter
`timescale 1ns/1ps
module fdl_chan_mon
  import fdl_pkg::*;
#(
  parameter int OPENLOAD_BYPASS_FLAG_DELAY = OPENLOAD_BYPASS_FLAG_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic chan_on,
  input  wire logic below_thresh,
  input  wire logic pwm_tick,
  input  wire logic integ_at_limit,
  output logic      openload_bypass_flag_event,
  output logic      reg_event
);

  logic [OPENLOAD_BYPASS_FLAG_W-1:0] low_cnt_q;
  logic [3:0]        pwm_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
    end else if (!chan_on || !below_thresh) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != OPENLOAD_BYPASS_FLAG_W'(OPENLOAD_BYPASS_FLAG_DELAY)) begin
      low_cnt_q <= low_cnt_q + OPENLOAD_BYPASS_FLAG_W'(1);
    end
  end

  assign openload_bypass_flag_event = chan_on && below_thresh && (low_cnt_q == OPENLOAD_BYPASS_FLAG_W'(OPENLOAD_BYPASS_FLAG_DELAY));

  // count pwm periods at the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_q <= '0;
    end else if (!integ_at_limit) begin
      pwm_cnt_q <= '0;
    end else if (pwm_tick && pwm_cnt_q != 4'(REG_PWM_LIM + 1)) begin
      pwm_cnt_q <= pwm_cnt_q + 4'h1;
    end
  end

  assign reg_event = integ_at_limit && (pwm_cnt_q > 4'(REG_PWM_LIM));

endmodule : fdl_chan_mon

/* File: fdl_top.sv */
// fdl_top: fault latching, channel shutdown, alert pin and APB registers
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fdl_top
  import fdl_pkg::*;
#(
  parameter int OPENLOAD_BYPASS_FLAG_DELAY = OPENLOAD_BYPASS_FLAG_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NCH-1:0]    overcurrent_det,
  input  wire logic [NCH-1:0]    overtemp_det,
  input  wire logic [NCH-1:0]    supply_low_det,
  input  wire logic [NCH-1:0]    load_below_thresh,
  input  wire logic [NCH-1:0]    load_pin_fault,
  input  wire logic [NCH-1:0]    pwm_tick,
  input  wire logic [NCH-1:0]    integ_at_limit,
  input  wire logic              pump_low_det,
  input  wire logic              battery_over_det,
  input  wire logic              crc_error_event,
  input  wire logic              watchdog_event,
  input  wire logic              external_reset_pin_n,
  input  wire logic              enable_pin,
  input  wire logic              supply_reset_act,
  input  wire logic              clock_fault,
  output logic [NCH-1:0]         chan_drive_on,
  output logic [NCH-1:0]         diag_src_on,
  output logic [NCH-1:0]         diag_src_pullup,
  output logic                   alert_pin_n_o,
  output logic                   alert_pin_n_oe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FDL_PWRUP = 2'b00,
    FDL_RUN   = 2'b01
  } fdl_state_t;

  fdl_state_t              state_q;
  logic [7:0]              ready_cnt_q;
  logic [NCH-1:0]          overcurrent_flag_q;
  logic [NCH-1:0]          openload_bypass_flag_q;
  logic [NCH-1:0]          overtemp_flag_q;
  logic [NCH-1:0]          supply_low_flag_q;
  logic [NCH-1:0]          regulation_error_flag_q;
  logic                    pump_low_flag_q;
  logic                    battery_over_flag_q;
  logic                    crc_error_flag_q;
  logic                    watchdog_flag_q;
  logic [NCH-1:0]          chan_en_q;
  logic [SETP_W-1:0]       setpoint_q [NCH];
  logic [NCH-1:0]          channel_alert_mask_q;
  logic                    enable_pin_alert_mask_q;
  logic [NCH-1:0]          offstate_current_select_q;
  logic [NCH-1:0]          offstate_open_flag;
  logic [NCH-1:0]          chan_armed;
  logic [NCH-1:0]          openload_bypass_flag_event;
  logic [NCH-1:0]          reg_event;
  logic [NCH-1:0]          chan_kill;
  logic                    wr_acc;
  logic                    rd_acc;
  logic                    diag_rd;
  logic [DATA_W-1:0]       diag_word;
  logic [DATA_W-1:0]       rd_word;
  logic                    rd_err;
  logic                    alert_any;
  logic [DATA_W-1:0]       keep_mask;

  function automatic logic [2:0] fdl_decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_DIAG) begin
      return 3'h0;
    end else if (a == ADDR_CONFIG) begin
      return 3'h1;
    end else if (a == ADDR_CHAN0) begin
      return 3'h2;
    end else if (a == ADDR_CHAN1) begin
      return 3'h3;
    end else if (a == ADDR_LIVE) begin
      return 3'h4;
    end else begin
      return 3'h7;
    end
  endfunction : fdl_decode

  // ------------------------------------------------------------
  // apb access: single-cycle access phase, pready high only in the access phase
  // ------------------------------------------------------------
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  // clear at completion of the diagnosis read, and only the bits it reported
  assign diag_rd = rd_acc && (fdl_decode(paddr) == 3'h0);
  assign keep_mask = diag_rd ? ~prdata : '1;

  // ------------------------------------------------------------
  // per-channel monitors
  // ------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      // armed means enabled with a nonzero setpoint
      assign chan_armed[c] = chan_en_q[c] && (setpoint_q[c] != '0);

      fdl_chan_mon #(
        .OPENLOAD_BYPASS_FLAG_DELAY (OPENLOAD_BYPASS_FLAG_DELAY)
      ) u_mon (
        .pclk           (pclk),
        .presetn        (presetn),
        // on-state check runs with the channel operating
        .chan_on        (chan_armed[c]),
        .below_thresh   (load_below_thresh[c]),
        .pwm_tick       (pwm_tick[c]),
        .integ_at_limit (integ_at_limit[c]),
        .openload_bypass_flag_event     (openload_bypass_flag_event[c]),
        .reg_event      (reg_event[c])
      );

      // live comparison, only meaningful with the source on
      assign offstate_open_flag[c] = diag_src_on[c] && load_pin_fault[c];

      // shutdown causes, crc excluded so channels keep running
      assign chan_kill[c] = (chan_armed[c] && overcurrent_det[c]) || openload_bypass_flag_event[c]
                          || overtemp_det[c] || supply_low_det[c]
                          || pump_low_det || battery_over_det;
    end
  endgenerate

  // ------------------------------------------------------------
  // latched flags: a set in the clearing cycle wins
  // ------------------------------------------------------------
  // overcurrent latch and read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overcurrent_flag_q <= '0;
    end else begin
      overcurrent_flag_q <= (overcurrent_flag_q & keep_mask[DIAG_OVC +: NCH])
                          | (chan_armed & overcurrent_det);
    end
  end

  // open-load flag, cleared only when condition gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      openload_bypass_flag_q <= '0;
    end else begin
      openload_bypass_flag_q <= openload_bypass_flag_event | (openload_bypass_flag_q
                                & (keep_mask[DIAG_OPENLOAD_BYPASS_FLAG +: NCH] | load_below_thresh));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overtemp_flag_q <= '0;
    end else begin
      overtemp_flag_q <= (overtemp_flag_q & keep_mask[DIAG_OT +: NCH]) | overtemp_det;
    end
  end

  // supply flags latched until read and back in range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_low_flag_q   <= '0;
      pump_low_flag_q     <= 1'b0;
      battery_over_flag_q <= 1'b0;
    end else begin
      supply_low_flag_q   <= (supply_low_flag_q & keep_mask[DIAG_UV +: NCH]) | supply_low_det;
      pump_low_flag_q     <= (pump_low_flag_q & keep_mask[DIAG_PUMP]) | pump_low_det;
      battery_over_flag_q <= (battery_over_flag_q & keep_mask[DIAG_BATOV]) | battery_over_det;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_error_flag_q        <= 1'b0;
      regulation_error_flag_q <= '0;
      watchdog_flag_q         <= 1'b0;
    end else begin
      crc_error_flag_q        <= (crc_error_flag_q & keep_mask[DIAG_CRC]) | crc_error_event;
      regulation_error_flag_q <= (regulation_error_flag_q & keep_mask[DIAG_RE +: NCH]) | reg_event;
      // watchdog status clears only by reset
      watchdog_flag_q         <= watchdog_flag_q | watchdog_event;
    end
  end

  // ------------------------------------------------------------
  // channel control registers
  // ------------------------------------------------------------
  generate
    for (c = 0; c < NCH; c++) begin : g_ctl
      // shutdown clears enable and setpoint, host must re-arm
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_en_q[c]  <= 1'b0;
          setpoint_q[c] <= '0;
        end else if (chan_kill[c]) begin
          chan_en_q[c]  <= 1'b0;
          setpoint_q[c] <= '0;
        end else if (wr_acc && fdl_decode(paddr) == 3'(2 + c)) begin
          chan_en_q[c]  <= pwdata[CH_EN];
          setpoint_q[c] <= pwdata[SETP_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_alert_mask_q      <= CFG_RESET[CFG_CHMASK +: NCH];
      enable_pin_alert_mask_q   <= CFG_RESET[CFG_ENMASK];
      offstate_current_select_q <= CFG_RESET[CFG_ISEL +: NCH];
    end else if (wr_acc && fdl_decode(paddr) == 3'h1) begin
      channel_alert_mask_q      <= pwdata[CFG_CHMASK +: NCH];
      enable_pin_alert_mask_q   <= pwdata[CFG_ENMASK];
      offstate_current_select_q <= pwdata[CFG_ISEL +: NCH];
    end
  end

  // ------------------------------------------------------------
  // drive outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_drive_on   <= '0;
      diag_src_on     <= '0;
      diag_src_pullup <= '0;
    end else begin
      chan_drive_on   <= chan_armed & ~chan_kill;
      for (int i = 0; i < NCH; i++) begin
        // source only while enabled at zero setpoint
        diag_src_on[i] <= chan_en_q[i] && (setpoint_q[i] == '0) && !chan_kill[i];
      end
      // select 1 picks the pull-up source
      diag_src_pullup <= offstate_current_select_q;
    end
  end

  // ------------------------------------------------------------
  // alert pin
  // ------------------------------------------------------------
  // or of unmasked faults only
  assign alert_any = |(channel_alert_mask_q & (overtemp_flag_q | overcurrent_flag_q
                                               | supply_low_flag_q | openload_bypass_flag_q))
                   || (enable_pin_alert_mask_q && !enable_pin)
                   || !external_reset_pin_n || supply_reset_act || clock_fault
                   || battery_over_flag_q || watchdog_flag_q;

  // hold the pin low for a short ready delay after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= FDL_PWRUP;
      ready_cnt_q <= '0;
    end else begin
      case (state_q)
        FDL_PWRUP: begin
          if (ready_cnt_q == 8'(READY_CYC - 1)) begin
            state_q <= FDL_RUN;
          end
          ready_cnt_q <= ready_cnt_q + 8'h01;
        end
        default: begin
          state_q <= FDL_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_pin_n_o  <= 1'b0;
      alert_pin_n_oe <= 1'b1;
    end else begin
      alert_pin_n_o  <= 1'b0;
      alert_pin_n_oe <= (state_q == FDL_PWRUP) || alert_any;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    diag_word = '0;
    diag_word[DIAG_OVC +: NCH]  = overcurrent_flag_q;
    diag_word[DIAG_OPENLOAD_BYPASS_FLAG +: NCH] = openload_bypass_flag_q;
    diag_word[DIAG_OT +: NCH]   = overtemp_flag_q;
    diag_word[DIAG_UV +: NCH]   = supply_low_flag_q;
    diag_word[DIAG_RE +: NCH]   = regulation_error_flag_q;
    diag_word[DIAG_PUMP]        = pump_low_flag_q;
    diag_word[DIAG_BATOV]       = battery_over_flag_q;
    diag_word[DIAG_CRC]         = crc_error_flag_q;
    diag_word[DIAG_WDOG]        = watchdog_flag_q;
  end

  always_comb begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (fdl_decode(paddr))
      3'h0: rd_word = diag_word;
      3'h1: begin
        rd_word[CFG_CHMASK +: NCH] = channel_alert_mask_q;
        rd_word[CFG_ENMASK]        = enable_pin_alert_mask_q;
        rd_word[CFG_ISEL +: NCH]   = offstate_current_select_q;
      end
      3'h2: begin
        rd_word[CH_EN]        = chan_en_q[0];
        rd_word[SETP_W-1:0]   = setpoint_q[0];
      end
      3'h3: begin
        rd_word[CH_EN]        = chan_en_q[1];
        rd_word[SETP_W-1:0]   = setpoint_q[1];
      end
      3'h4: rd_word[NCH-1:0] = offstate_open_flag;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // answer registered in the setup cycle, valid through the access phase
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_word : '0;
      pslverr <= psel && !penable && rd_err;
    end
  end

endmodule : fdl_top

/* File: fdl_checker.sv */
// fdl_checker: port-level assertions for the fault diagnosis block
`timescale 1ns/1ps
module fdl_checker
  import fdl_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [NCH-1:0]    overcurrent_det,
  input wire logic [NCH-1:0]    overtemp_det,
  input wire logic              pump_low_det,
  input wire logic              battery_over_det,
  input wire logic              external_reset_pin_n,
  input wire logic              enable_pin,
  input wire logic              clock_fault,
  input wire logic [NCH-1:0]    chan_drive_on,
  input wire logic [NCH-1:0]    diag_src_on,
  input wire logic              alert_pin_n_o,
  input wire logic              alert_pin_n_oe
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [2:0] mask_q;
  logic [7:0] up_q;
  logic [1:0] arm_q;
  logic       wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  // mirrors the alert masks, updated at the same edge as the block's copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_q <= CFG_RESET[2:0];
    else if (wr_acc && paddr == ADDR_CONFIG) mask_q <= pwdata[2:0];
  end
  // saturates so a long run never wraps back into the power-up window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= '0;
    else if (up_q != 8'hff) up_q <= up_q + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) arm_q <= '0;
    else arm_q <= {arm_q[0], wr_acc && paddr == ADDR_CHAN0};
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PIN_LOW_ONLY: assert property (alert_pin_n_o == 1'b0)
    else $error("alert output level not low");
  AST_READY_HOLD: assert property (up_q < READY_CYC |-> alert_pin_n_oe)
    else $error("alert released inside power-up window");
  AST_HARD_FAULTS: assert property (!external_reset_pin_n || clock_fault |-> ##[1:2] alert_pin_n_oe)
    else $error("reset pin or clock fault did not pull alert");
  AST_ENABLE_MASK: assert property (!enable_pin && mask_q[2] |-> ##[1:3] alert_pin_n_oe)
    else $error("low enable pin with mask set did not pull alert");
  AST_CHAN_MASK: assert property (overtemp_det[1] && mask_q[1] |-> ##[1:3] alert_pin_n_oe)
    else $error("unmasked channel fault did not pull alert");
  AST_OVC_SHUTDOWN: assert property (overcurrent_det[0] && chan_drive_on[0] |-> ##[1:2] !chan_drive_on[0])
    else $error("overcurrent left channel driving");
  AST_REARM_BY_WRITE: assert property ($rose(chan_drive_on[0]) |-> arm_q != 2'b00)
    else $error("channel came on without a host write");
  AST_SRC_OFF_DRIVEN: assert property (chan_drive_on[0] && $stable(chan_drive_on[0]) |-> !diag_src_on[0])
    else $error("diagnostic source on while channel drives");
  AST_PUMP_ALL_OFF: assert property (pump_low_det |-> ##[1:2] chan_drive_on == '0)
    else $error("pump undervoltage left a channel on");
  AST_BATT_ALERT: assert property (battery_over_det |-> ##[1:3] alert_pin_n_oe)
    else $error("battery overvoltage did not pull alert");
  COV_OVC: cover property (overcurrent_det[0] && chan_drive_on[0]);
  COV_PUMP: cover property (pump_low_det && chan_drive_on != '0);
  COV_SRC: cover property ($rose(diag_src_on[0]));
endmodule : fdl_checker

/* File: fdl_host.sv */
// fdl_host: host model issuing register transfers and watching the alert line
`timescale 1ns/1ps
module fdl_host
  import fdl_pkg::*;
(
  input  wire logic              pclk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [DATA_W-1:0] pwdata,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  input  wire logic              alert_line_n
);
  int alerts = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // host counts each falling edge of the alert line
  always @(negedge alert_line_n) alerts <= alerts + 1;
  // one idle edge first, so a release is never overwritten in the same step
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fdl_host

/* File: test_fault_diagnosis_logic.sv */
// test_fault_diagnosis_logic: scenario bench for the fault diagnosis block
`timescale 1ns/1ps
module test_fault_diagnosis_logic
  import fdl_pkg::*;
();
  localparam int          OLD = 16;
  localparam logic [31:0] ARM = 32'h0001_0005;
  logic              pclk = 1'b0;
  logic              presetn;
  logic              psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, r;
  logic [NCH-1:0]    ovc, ot, slow, lbt, lpf, tick, ilim, drive_on, src_on, src_pu;
  logic [3:0]        misc;
  logic              pump, crc, wdog, en_pin, alert_o, alert_oe, e;
  wire               alert_line_n = alert_oe ? alert_o : 1'b1;
  int                error_cnt = 0;
  int                compares = 0;
  int                cyc = 0;
  always #2.5 pclk = ~pclk;
  fdl_top #(.OPENLOAD_BYPASS_FLAG_DELAY(OLD)) i_fdl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overcurrent_det(ovc), .overtemp_det(ot),
    .supply_low_det(slow), .load_below_thresh(lbt), .load_pin_fault(lpf), .pwm_tick(tick),
    .integ_at_limit(ilim), .pump_low_det(pump), .battery_over_det(misc[2]),
    .crc_error_event(crc), .watchdog_event(wdog), .external_reset_pin_n(~misc[3]),
    .enable_pin(en_pin), .supply_reset_act(misc[1]), .clock_fault(misc[0]),
    .chan_drive_on(drive_on), .diag_src_on(src_on), .diag_src_pullup(src_pu),
    .alert_pin_n_o(alert_o), .alert_pin_n_oe(alert_oe));
  fdl_host i_fdl_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alert_line_n(alert_line_n));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask : cy
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_fdl_host.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    i_fdl_host.xfer(1'b0, a, '0, r, e);
    chk(r, x);
  endtask : rdc
  task automatic results();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ready();
    chk(alert_oe, 1);
    cy(READY_CYC + 3);
    chk(alert_oe, 0);
    rdc(ADDR_CONFIG, CFG_RESET);
    i_fdl_host.xfer(1'b0, 12'h0fc, '0, r, e);
    chk(r, 32'h0);
    chk(e, 1);
  endtask : t_ready
  task automatic t_ovc();
    ovc[0] <= 1'b1; cy(2); ovc[0] <= 1'b0; // unarmed channel ignores overcurrent
    rdc(ADDR_DIAG, 0);
    wr(ADDR_CHAN0, ARM); cy(2);
    chk(drive_on[0], 1);
    ovc[0] <= 1'b1; cy(1); ovc[0] <= 1'b0; cy(3);
    chk(drive_on[0], 0);
    chk(alert_oe, 1);
    chk(i_fdl_host.alerts > 0, 1);
    rdc(ADDR_CHAN0, 0);
    rdc(ADDR_DIAG, 32'h1);
    rdc(ADDR_DIAG, 0);
    cy(3); chk(alert_oe, 0);
    wr(ADDR_CHAN0, ARM); cy(2); chk(drive_on[0], 1);
    wr(ADDR_CHAN0, 0);
  endtask : t_ovc
  task automatic t_mask();
    ot[1] <= 1'b1; cy(4); chk(alert_oe, 1);
    wr(ADDR_CONFIG, 0); cy(3); chk(alert_oe, 0);
    rdc(ADDR_DIAG, 32'h20);
    ot[1] <= 1'b0; cy(2);
    rdc(ADDR_DIAG, 32'h20);
    rdc(ADDR_DIAG, 0);
    en_pin <= 1'b0; cy(4); chk(alert_oe, 0);
    wr(ADDR_CONFIG, 32'h4); cy(3); chk(alert_oe, 1);
    en_pin <= 1'b1; cy(3); chk(alert_oe, 0);
    for (int i = 0; i < 4; i++) begin
      misc[i] <= 1'b1; cy(3); chk(alert_oe, 1);
      misc[i] <= 1'b0; cy(3);
    end
    rdc(ADDR_DIAG, 32'h800);
    cy(3); chk(alert_oe, 0);
  endtask : t_mask
  task automatic t_openload_bypass_flag();
    wr(ADDR_CHAN1, ARM); lbt[1] <= 1'b1;
    cy(OLD - 2); chk(drive_on[1], 1);
    cy(8); chk(drive_on[1], 0);
    rdc(ADDR_DIAG, 32'h8);
    rdc(ADDR_DIAG, 32'h8);
    lbt[1] <= 1'b0;
    rdc(ADDR_DIAG, 32'h8);
    rdc(ADDR_DIAG, 0);
  endtask : t_openload_bypass_flag
  task automatic t_off();
    // host selects the pull-up first, then the pull-down, waiting between
    wr(ADDR_CONFIG, 32'h17); wr(ADDR_CHAN0, 32'h0001_0000); cy(2);
    chk(src_on, 2'b01);
    chk(src_pu[0], 1);
    lpf[0] <= 1'b1; cy(2); rdc(ADDR_LIVE, 1);
    lpf[0] <= 1'b0; cy(2); rdc(ADDR_LIVE, 0);
    wr(ADDR_CONFIG, 32'h7); cy(2); chk(src_pu[0], 0);
    wr(ADDR_CHAN0, ARM); cy(2); chk(src_on[0], 0);
    wr(ADDR_CHAN0, 0); cy(2); chk(src_on[0], 0);
  endtask : t_off
  task automatic t_reg();
    ilim[0] <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (i == 8) rdc(ADDR_DIAG, 0);
      tick[0] <= 1'b1; cy(1); tick[0] <= 1'b0; cy(1);
    end
    ilim[0] <= 1'b0; cy(2);
    rdc(ADDR_DIAG, 32'h100);
    rdc(ADDR_DIAG, 0);
  endtask : t_reg
  task automatic t_pump();
    wr(ADDR_CHAN0, ARM); wr(ADDR_CHAN1, ARM); cy(2);
    crc <= 1'b1; cy(1); crc <= 1'b0; cy(3);
    chk(drive_on, 2'b11);
    rdc(ADDR_DIAG, 32'h1000);
    rdc(ADDR_DIAG, 0);
    // checksum event lands after the read word is captured but before the clear
    fork
      rdc(ADDR_DIAG, 0);
      begin
        cy(1);
        crc <= 1'b1;
        cy(1);
        crc <= 1'b0;
      end
    join
    rdc(ADDR_DIAG, 32'h1000);
    pump <= 1'b1; cy(3); chk(drive_on, 0);
    wr(ADDR_CHAN0, ARM); cy(2); chk(drive_on, 0);
    pump <= 1'b0; rdc(ADDR_DIAG, 32'h400);
    wr(ADDR_CHAN0, ARM); cy(2); chk(drive_on[0], 1);
    wr(ADDR_CHAN0, 0);
  endtask : t_pump
  task automatic t_wdog();
    wdog <= 1'b1; cy(1); wdog <= 1'b0; cy(3);
    chk(alert_oe, 1);
    rdc(ADDR_DIAG, 32'h2000);
    rdc(ADDR_DIAG, 32'h2000);
    presetn <= 1'b0; cy(2); presetn <= 1'b1;
    cy(2); chk(alert_oe, 1);
    cy(READY_CYC + 3); chk(alert_oe, 0);
  endtask : t_wdog
  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    {ovc, ot, slow, lbt, lpf, tick, ilim} = '0;
    {misc, pump, crc, wdog} = '0;
    en_pin = 1'b1;
    presetn = 1'b0;
    cy(6);
    presetn <= 1'b1;
    t_ready();
    t_ovc();
    t_mask();
    t_openload_bypass_flag();
    t_off();
    t_reg();
    t_pump();
    t_wdog();
    results();
  end
endmodule : test_fault_diagnosis_logic
bind fdl_top fdl_checker i_fdl_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .overcurrent_det(overcurrent_det), .overtemp_det(overtemp_det),
  .pump_low_det(pump_low_det), .battery_over_det(battery_over_det),
  .external_reset_pin_n(external_reset_pin_n), .enable_pin(enable_pin),
  .clock_fault(clock_fault), .chan_drive_on(chan_drive_on), .diag_src_on(diag_src_on),
  .alert_pin_n_o(alert_pin_n_o), .alert_pin_n_oe(alert_pin_n_oe));
